// file: gpl_pkg.sv
// Constants shared by the general-purpose port with LED drive
package gpl_pkg;

	// ------------------------------------------------------------
	// I/O-space locations
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_PIN_INPUT    = 8'h00;
	localparam logic [7:0] ADDR_DIRECTION    = 8'h01;
	localparam logic [7:0] ADDR_OUTPUT_LATCH = 8'h02;
	localparam logic [7:0] ADDR_MCU_CONTROL  = 8'h35;
	localparam logic [7:0] ADDR_LED_CONFIG   = 8'h75;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int         PUD_BIT_POS       = 4;
	localparam int         LED_FIELD_WIDTH   = 2;
	localparam logic [7:0] RST_OUTPUT_LATCH  = 8'h00;
	localparam logic [7:0] RST_DIRECTION     = 8'h00;
	localparam logic [7:0] RST_LED_CONFIG    = 8'h00;
	localparam logic       RST_PULLUP_DIS    = 1'h0;
	localparam logic [7:0] RST_READ_DATA     = 8'h00;
	localparam logic [2:0] RST_SYNC          = 3'h0;

	// ------------------------------------------------------------
	// LED channel current modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		GPL_LED_OFF  = 2'h0,
		GPL_LED_2MA  = 2'h1,
		GPL_LED_4MA  = 2'h2,
		GPL_LED_RSVD = 2'h3
	} gpl_led_mode_t;

endpackage

// file: gpl_port.sv
// Eight-pin general-purpose port with pull-ups, toggle and LED current drive
//
// Behaviour
// - Set or clear of one bit changes only that pin's direction, latch or pull-up.
// - Each port has latch, direction and pin input locations.
// - Pin input location is read-only; latch and direction are read/write.
// - Writing one to a pin input bit inverts the latch bit; zero does nothing.
// - Global pull-up disable switches off every pull-up.
// - Alternate functions on some pins leave other pins usable as plain I/O.
// - Keyboard pad current control is off in the deep sleep modes.
// - LED field: 00 off, 01 two milliamp, 10 four milliamp, 11 reserved.
// - LED register: channel 3 bits 7..6 down to channel 0 bits 1..0; resets zero.
// - Direction one drives the pin; direction zero makes it an input.
// - Input with latch one and pull-up disable zero enables the pull-up.
// - Reset tri-states every pin without an alternate function enabled at once, with no clock needed.
// - Output pin drives the latch value.
// - Pin decode: pull-up only for input with latch one; never on outputs.
// - Strobes are shared by a port's pins; clock, clamp, pull-up disable by all.
// - Pull-up disable is bit 4 of the control register, read/write, resets zero.
// - Pin input is synchronised before it lands in the input bit.
// - Deep sleep clamps the input path low except on interrupt-enabled pins.
`timescale 1ns/1ps

module gpl_port #(
	parameter int WIDTH  = 8,
	parameter int LED_CH = 4
) (
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire logic              ce,
	input  wire logic [7:0]        io_addr,
	input  wire logic [7:0]        io_wdata,
	input  wire logic              io_we,
	input  wire logic              io_re,
	input  wire logic              io_bit_set,
	input  wire logic              io_bit_clr,
	input  wire logic [2:0]        io_bit_idx,
	output logic      [7:0]        io_rdata,
	input  wire logic [2*LED_CH-1:0] led_cfg_in,
	input  wire logic              sleep_deep,
	input  wire logic [WIDTH-1:0]  ext_int_en,
	input  wire logic [WIDTH-1:0]  alt_en,
	input  wire logic [WIDTH-1:0]  alt_oe,
	input  wire logic [WIDTH-1:0]  alt_out,
	input  wire logic [WIDTH-1:0]  pad_in,
	output logic      [WIDTH-1:0]  pad_out,
	output logic      [WIDTH-1:0]  pad_oe,
	output logic      [WIDTH-1:0]  pullup_en,
	output logic      [WIDTH-1:0]  low_drive_en,
	output logic      [LED_CH-1:0] led_src_2ma,
	output logic      [LED_CH-1:0] led_src_4ma,
	output logic                   kbo_ctrl_en,
	output logic      [WIDTH-1:0]  pad_in_sync
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [WIDTH-1:0]    output_latch_ff;
	logic [WIDTH-1:0]    direction_ff;
	logic [WIDTH-1:0]    pin_input_ff;
	logic                pullup_disable_ff;
	logic [2*LED_CH-1:0] led_cfg_ff;
	logic [WIDTH-1:0]    sync1_ff;
	logic [WIDTH-1:0]    sync2_ff;
	logic [WIDTH-1:0]    sync3_ff;
	logic [7:0]          rdata_ff;
	logic [WIDTH-1:0]    clamped_in;
	logic [WIDTH-1:0]    nxt_pin_input;
	logic [WIDTH-1:0]    bit_mask;

	function automatic logic [WIDTH-1:0] one_hot(input logic [2:0] idx);
		one_hot = '0;
		one_hot[idx] = 1'b1;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] loc);
		hit = (a == loc);
	endfunction

	assign bit_mask = one_hot(io_bit_idx);

	// ------------------------------------------------------------
	// Output latch: write, toggle via pin location, bit set/clear
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			output_latch_ff <= gpl_pkg::RST_OUTPUT_LATCH[WIDTH-1:0];
		end else if (ce) begin
			if (io_we && hit(io_addr, gpl_pkg::ADDR_OUTPUT_LATCH)) begin
				output_latch_ff <= io_wdata[WIDTH-1:0];
			end else if (io_we && hit(io_addr, gpl_pkg::ADDR_PIN_INPUT)) begin
				output_latch_ff <= output_latch_ff ^ io_wdata[WIDTH-1:0];
			end else if (io_bit_set && hit(io_addr, gpl_pkg::ADDR_OUTPUT_LATCH)) begin
				output_latch_ff <= output_latch_ff | bit_mask;
			end else if (io_bit_clr && hit(io_addr, gpl_pkg::ADDR_OUTPUT_LATCH)) begin
				output_latch_ff <= output_latch_ff & ~bit_mask;
			end else if (io_bit_set && hit(io_addr, gpl_pkg::ADDR_PIN_INPUT)) begin
				output_latch_ff <= output_latch_ff ^ bit_mask;
			end
		end
	end

	// ------------------------------------------------------------
	// Direction
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			direction_ff <= gpl_pkg::RST_DIRECTION[WIDTH-1:0];
		end else if (ce) begin
			if (io_we && hit(io_addr, gpl_pkg::ADDR_DIRECTION)) begin
				direction_ff <= io_wdata[WIDTH-1:0];
			end else if (io_bit_set && hit(io_addr, gpl_pkg::ADDR_DIRECTION)) begin
				direction_ff <= direction_ff | bit_mask;
			end else if (io_bit_clr && hit(io_addr, gpl_pkg::ADDR_DIRECTION)) begin
				direction_ff <= direction_ff & ~bit_mask;
			end
		end
	end

	// ------------------------------------------------------------
	// Control register: only the pull-up disable lives here
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pullup_disable_ff <= gpl_pkg::RST_PULLUP_DIS;
		end else if (ce) begin
			if (io_we && hit(io_addr, gpl_pkg::ADDR_MCU_CONTROL)) begin
				pullup_disable_ff <= io_wdata[gpl_pkg::PUD_BIT_POS];
			end else if (io_bit_set && hit(io_addr, gpl_pkg::ADDR_MCU_CONTROL)
				&& io_bit_idx == 3'(gpl_pkg::PUD_BIT_POS)) begin
				pullup_disable_ff <= 1'b1;
			end else if (io_bit_clr && hit(io_addr, gpl_pkg::ADDR_MCU_CONTROL)
				&& io_bit_idx == 3'(gpl_pkg::PUD_BIT_POS)) begin
				pullup_disable_ff <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// LED configuration, read-only to software
	// ------------------------------------------------------------
	// Loaded from the configuration source, never from the I/O bus
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			led_cfg_ff <= gpl_pkg::RST_LED_CONFIG[2*LED_CH-1:0];
		end else if (ce) begin
			led_cfg_ff <= led_cfg_in;
		end
	end

	// ------------------------------------------------------------
	// Input path: sleep clamp, then three-stage synchroniser
	// ------------------------------------------------------------
	// Clamp keeps floating pads from burning current in deep sleep
	assign clamped_in = pad_in & ~({WIDTH{sleep_deep}} & ~ext_int_en);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
		end else if (ce) begin
			sync1_ff <= clamped_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// A change is accepted only once the last two stages agree
	always_comb begin
		nxt_pin_input = pin_input_ff;
		for (int i = 0; i < WIDTH; i++) begin
			if (sync2_ff[i] == sync3_ff[i]) begin
				nxt_pin_input[i] = sync3_ff[i];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pin_input_ff <= '0;
		end else if (ce) begin
			pin_input_ff <= nxt_pin_input;
		end
	end

	assign pad_in_sync = pin_input_ff;

	// ------------------------------------------------------------
	// Read data, one cycle after the read strobe
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= gpl_pkg::RST_READ_DATA;
		end else if (ce && io_re) begin
			unique case (io_addr)
				gpl_pkg::ADDR_PIN_INPUT:    rdata_ff <= 8'(pin_input_ff);
				gpl_pkg::ADDR_DIRECTION:    rdata_ff <= 8'(direction_ff);
				gpl_pkg::ADDR_OUTPUT_LATCH: rdata_ff <= 8'(output_latch_ff);
				gpl_pkg::ADDR_MCU_CONTROL:  rdata_ff <= 8'(pullup_disable_ff) << gpl_pkg::PUD_BIT_POS;
				gpl_pkg::ADDR_LED_CONFIG:   rdata_ff <= 8'(led_cfg_ff);
				default:                    rdata_ff <= 8'h00;
			endcase
		end
	end

	assign io_rdata = rdata_ff;

	// ------------------------------------------------------------
	// Pad control
	// ------------------------------------------------------------
	// Alternate function takes a pin only where its enable is set
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_pin
			logic led_on;
			if (g < LED_CH) begin : g_led
				assign led_on = led_cfg_ff[2*g +: 2] != gpl_pkg::GPL_LED_OFF;
			end else begin : g_noled
				assign led_on = 1'b0;
			end
			assign pad_oe[g]    = alt_en[g] ? alt_oe[g] : direction_ff[g];
			assign pad_out[g]   = alt_en[g] ? alt_out[g] : output_latch_ff[g];
			assign pullup_en[g] = !alt_en[g] && !direction_ff[g]
				&& output_latch_ff[g] && !pullup_disable_ff;
			// LED channels give up the strong low side to the current source
			assign low_drive_en[g] = pad_oe[g] && !pad_out[g] && !led_on;
		end
		for (g = 0; g < LED_CH; g++) begin : g_src
			assign led_src_2ma[g] = led_cfg_ff[2*g +: 2] == gpl_pkg::GPL_LED_2MA
				&& !output_latch_ff[g];
			assign led_src_4ma[g] = led_cfg_ff[2*g +: 2] == gpl_pkg::GPL_LED_4MA
				&& !output_latch_ff[g];
		end
	endgenerate

	assign kbo_ctrl_en = !sleep_deep;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_pud_write;
		ce && io_we && io_addr == gpl_pkg::ADDR_MCU_CONTROL;
	endsequence
	sequence s_pud_read;
		ce && io_re && io_addr == gpl_pkg::ADDR_MCU_CONTROL && !io_we && !io_bit_set && !io_bit_clr;
	endsequence

	property p_toggle;
		ce && io_we && io_addr == gpl_pkg::ADDR_PIN_INPUT
		|=> output_latch_ff == ($past(output_latch_ff) ^ $past(io_wdata[WIDTH-1:0]));
	endproperty
	a_toggle: assert property (p_toggle) else $error("latch did not toggle");

	property p_dir_set;
		ce && io_bit_set && !io_we && io_addr == gpl_pkg::ADDR_DIRECTION
		|=> direction_ff == ($past(direction_ff) | one_hot($past(io_bit_idx)));
	endproperty
	a_dir_set: assert property (p_dir_set) else $error("bit set disturbed other pins");

	property p_latch_clr;
		ce && io_bit_clr && !io_we && !io_bit_set && io_addr == gpl_pkg::ADDR_OUTPUT_LATCH
		|=> output_latch_ff == ($past(output_latch_ff) & ~one_hot($past(io_bit_idx)));
	endproperty
	a_latch_clr: assert property (p_latch_clr) else $error("bit clear wrong");

	property p_pullup;
		(pullup_disable_ff || direction_ff != '0) |-> (pullup_en & (direction_ff
			| {WIDTH{pullup_disable_ff}})) == '0;
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up on while barred");

	property p_pud_rw;
		s_pud_write ##1 (!io_we && !io_bit_set && !io_bit_clr) ##1 s_pud_read
		|=> io_rdata[gpl_pkg::PUD_BIT_POS] == $past(io_wdata[gpl_pkg::PUD_BIT_POS], 3);
	endproperty
	a_pud_rw: assert property (p_pud_rw) else $error("pull-up disable readback wrong");

	property p_reset_tristate;
		$rose(rst_b) |-> pad_oe == (alt_en & alt_oe) && output_latch_ff == '0;
	endproperty
	a_reset_tristate: assert property (p_reset_tristate) else $error("pin driven after reset");

	property p_sync;
		(ce && !sleep_deep && $stable(pad_in))[*5] |=> pin_input_ff == $past(pad_in);
	endproperty
	a_sync: assert property (p_sync) else $error("input not captured");

	property p_led_read;
		ce && io_re && io_addr == gpl_pkg::ADDR_LED_CONFIG |=> io_rdata == 8'($past(led_cfg_ff));
	endproperty
	a_led_read: assert property (p_led_read) else $error("LED config readback wrong");

	property p_led_src;
		led_cfg_ff[1:0] == gpl_pkg::GPL_LED_4MA && !output_latch_ff[0]
		|-> led_src_4ma[0] && !led_src_2ma[0] && !low_drive_en[0];
	endproperty
	a_led_src: assert property (p_led_src) else $error("LED source select wrong");

	property p_output_drive;
		!alt_en[0] && direction_ff[0] |-> pad_oe[0] && pad_out[0] == output_latch_ff[0];
	endproperty
	a_output_drive: assert property (p_output_drive) else $error("output not driven");

	property p_clamp;
		(ce && sleep_deep && !ext_int_en[1])[*5] |=> !pin_input_ff[1];
	endproperty
	a_clamp: assert property (p_clamp) else $error("sleep clamp missing");

	property p_kbo;
		sleep_deep |-> !kbo_ctrl_en;
	endproperty
	a_kbo: assert property (p_kbo) else $error("keyboard control active in sleep");

endmodule

// file: gpl_pad_model.sv
// Pad-side model: resolves each pin from port drive, external drive and pull-up
`timescale 1ns/1ps

module gpl_pad_model (
	input  wire logic       clock,
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	input  wire logic [7:0] pullup_en,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pad_in
);
	logic [7:0] float_ff = 8'h55;

	// A pin nobody drives changes every cycle, so a stale value never reads as right
	always @(posedge clock) begin
		float_ff <= ~float_ff;
	end

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i]) begin
				pad_in[i] = pad_out[i];
			end else if (ext_en[i]) begin
				pad_in[i] = ext_val[i];
			end else if (pullup_en[i]) begin
				pad_in[i] = 1'b1;
			end else begin
				pad_in[i] = float_ff[i];
			end
		end
	end
endmodule

// file: gpl_port_bench.sv
// Self-checking bench for the eight-pin port
`timescale 1ns/1ps

module gpl_port_bench;
	logic clock = 0, rst_b = 0, ce = 1, io_we = 0, io_re = 0, io_bit_set = 0, io_bit_clr = 0;
	logic sleep_deep = 0, kbo_ctrl_en;
	logic [2:0] io_bit_idx = 3'h0;
	logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, led_cfg_in = 8'h00;
	logic [7:0] ext_int_en = 8'h00, alt_en = 8'h00, alt_oe = 8'h00, alt_out = 8'h00;
	logic [7:0] pad_in, pad_out, pad_oe, pullup_en, low_drive_en, pad_in_sync;
	logic [7:0] ext_en = 8'h00, ext_val = 8'h00, rd;
	logic [3:0] led_src_2ma, led_src_4ma;
	int bad_count = 0, cmp_count = 0, cyc = 0;

	always #10 clock = ~clock;

	gpl_port dut_u (.clock(clock), .rst_b(rst_b), .ce(ce), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_we(io_we), .io_re(io_re), .io_bit_set(io_bit_set),
		.io_bit_clr(io_bit_clr), .io_bit_idx(io_bit_idx), .io_rdata(io_rdata),
		.led_cfg_in(led_cfg_in), .sleep_deep(sleep_deep), .ext_int_en(ext_int_en),
		.alt_en(alt_en), .alt_oe(alt_oe), .alt_out(alt_out), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .pullup_en(pullup_en),
		.low_drive_en(low_drive_en), .led_src_2ma(led_src_2ma),
		.led_src_4ma(led_src_4ma), .kbo_ctrl_en(kbo_ctrl_en), .pad_in_sync(pad_in_sync));

	gpl_pad_model pads_u (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe),
		.pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		io_addr <= a;
		io_wdata <= d;
		io_we <= 1'b1;
		@(posedge clock);
		io_we <= 1'b0;
	endtask

	task automatic bitop(input logic set, input logic [7:0] a, input logic [2:0] idx);
		@(posedge clock);
		io_addr <= a;
		io_bit_idx <= idx;
		io_bit_set <= set;
		io_bit_clr <= ~set;
		@(posedge clock);
		io_bit_set <= 1'b0;
		io_bit_clr <= 1'b0;
	endtask

	task automatic rdreg(input logic [7:0] a);
		@(posedge clock);
		io_addr <= a;
		io_re <= 1'b1;
		@(posedge clock);
		io_re <= 1'b0;
		#1;
		rd = io_rdata;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Ceiling well above the hundred or so cycles the sequence needs
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		step(15);
		chk("oe in reset", 8'h00, pad_oe);
		chk("pullup in reset", 8'h00, pullup_en);
		@(posedge clock);
		rst_b <= 1'b1;
		rdreg(gpl_pkg::ADDR_DIRECTION); chk("dir reset", 8'h00, rd);
		rdreg(gpl_pkg::ADDR_OUTPUT_LATCH); chk("latch reset", 8'h00, rd);
		rdreg(gpl_pkg::ADDR_MCU_CONTROL); chk("ctrl reset", 8'h00, rd);
		rdreg(gpl_pkg::ADDR_LED_CONFIG); chk("led reset", 8'h00, rd);
		// Latch first, so high outputs pass through the pull-up state
		wr(gpl_pkg::ADDR_OUTPUT_LATCH, 8'hF0);
		step(1); chk("pullup via latch", 8'hF0, pullup_en);
		wr(gpl_pkg::ADDR_DIRECTION, 8'h0F);
		bitop(1'b1, gpl_pkg::ADDR_DIRECTION, 3'h5);
		bitop(1'b0, gpl_pkg::ADDR_OUTPUT_LATCH, 3'h7);
		step(1);
		chk("oe", 8'h2F, pad_oe);
		chk("out", 8'h70, pad_out);
		chk("pullup decode", 8'h50, pullup_en);
		// Pull-up input to output low by way of output high, then back
		bitop(1'b1, gpl_pkg::ADDR_DIRECTION, 3'h6);
		bitop(1'b0, gpl_pkg::ADDR_OUTPUT_LATCH, 3'h6);
		step(1); chk("output low via high", 8'h40, pad_oe & ~pad_out & 8'h40);
		bitop(1'b1, gpl_pkg::ADDR_OUTPUT_LATCH, 3'h6);
		bitop(1'b0, gpl_pkg::ADDR_DIRECTION, 3'h6);
		wr(gpl_pkg::ADDR_MCU_CONTROL, 8'h10);
		step(1); chk("pullup disabled", 8'h00, pullup_en);
		rdreg(gpl_pkg::ADDR_MCU_CONTROL); chk("ctrl rw", 8'h10, rd);
		wr(gpl_pkg::ADDR_MCU_CONTROL, 8'h00);
		rdreg(gpl_pkg::ADDR_MCU_CONTROL); chk("ctrl cleared", 8'h00, rd);
		// Toggle through the input location; clear there and LED writes do nothing
		wr(gpl_pkg::ADDR_PIN_INPUT, 8'h81);
		bitop(1'b1, gpl_pkg::ADDR_PIN_INPUT, 3'h1);
		bitop(1'b0, gpl_pkg::ADDR_PIN_INPUT, 3'h0);
		wr(gpl_pkg::ADDR_LED_CONFIG, 8'hFF);
		rdreg(gpl_pkg::ADDR_OUTPUT_LATCH); chk("latch toggled", 8'hF3, rd);
		rdreg(gpl_pkg::ADDR_DIRECTION); chk("dir kept", 8'h2F, rd);
		rdreg(8'h40); chk("unmapped", 8'h00, rd);
		rdreg(gpl_pkg::ADDR_LED_CONFIG); chk("led ro", 8'h00, rd);
		// Clock enable low must swallow a write
		ce <= 1'b0;
		wr(gpl_pkg::ADDR_OUTPUT_LATCH, 8'h00);
		ce <= 1'b1;
		rdreg(gpl_pkg::ADDR_OUTPUT_LATCH); chk("ce freeze", 8'hF3, rd);
		// Inputs driven externally, outputs read back after the sync delay
		ext_val <= 8'hA5;
		ext_en <= 8'hFF;
		step(6);
		rdreg(gpl_pkg::ADDR_PIN_INPUT); chk("pin reg", 8'hA3, rd);
		chk("pin sync", 8'hA3, pad_in_sync);
		sleep_deep <= 1'b1;
		ext_int_en <= 8'h80;
		step(6);
		chk("clamp", 8'h80, pad_in_sync);
		chk("kbo off", 8'h00, {7'h00, kbo_ctrl_en});
		sleep_deep <= 1'b0;
		step(1); chk("kbo on", 8'h01, {7'h00, kbo_ctrl_en});
		// Channel 3 reserved, 2 at 4 mA, 1 at 2 mA, 0 off
		led_cfg_in <= 8'hE4;
		step(2);
		rdreg(gpl_pkg::ADDR_LED_CONFIG); chk("led fields", 8'hE4, rd);
		chk("src 4ma", 8'h04, {4'h0, led_src_4ma});
		chk("src 2ma idle", 8'h00, {4'h0, led_src_2ma});
		wr(gpl_pkg::ADDR_PIN_INPUT, 8'h02);
		step(1);
		chk("src 2ma", 8'h02, {4'h0, led_src_2ma});
		chk("low drv off", 8'h00, {5'h00, low_drive_en[3:1]});
		alt_en <= 8'h10;
		alt_oe <= 8'h10;
		step(1);
		chk("alt oe", 8'h3F, pad_oe);
		chk("alt out", 8'hE1, pad_out);
		@(posedge clock);
		rst_b <= 1'b0;
		#1;
		chk("async reset oe", 8'h10, pad_oe);
		alt_en <= 8'h00;
		step(2);
		chk("reset oe", 8'h00, pad_oe);
		rst_b <= 1'b1;
		rdreg(gpl_pkg::ADDR_OUTPUT_LATCH); chk("latch re-reset", 8'h00, rd);
		summarize();
	end
endmodule
